// *** logic/relay_defines.svh ***
// Purpose: named offsets, fields, reset values and timing for the relay scanner block
// Assumes: 200 MHz sys_clk
// Notes:   byte addresses on the plain register port, one word each
`ifndef RELAY_DEFINES_SVH
`define RELAY_DEFINES_SVH

`define A_CLOSE      8'h00
`define A_OPEN       8'h04
`define A_PULSE      8'h08
`define A_PWIDTH     8'h0C
`define A_STATE      8'h10
`define A_SCAN_ENTRY 8'h14
`define A_SCAN_LEN   8'h18
`define A_INIT_IMM   8'h1C
`define A_INIT_CONT  8'h20
`define A_TRIGGER    8'h24
`define A_SAVE       8'h28
`define A_SCAN_STAT  8'h2C
`define A_COND       8'h30
`define A_EVENT      8'h34
`define A_ENABLE     8'h38
`define A_PTR        8'h3C
`define A_NTR        8'h40
`define A_STB        8'h44

`define ENT_IDX_LSB  16
`define ENT_IDX_MSB  20
`define STEPS        6'h20
`define LEN_W        6
`define NV_ADDR_LEN  6'h00
`define SAVE_ARG     32'h0000_0000
`define PW_DEFAULT   16'h0019
`define PW_MIN       16'h0001
`define PW_MAX       16'h7530
`define SB_QSUM      3
`define SB_RQS       6

`define CLK_MHZ      200
`define BREAK_NS     100
`define BREAK_CYC    ((`BREAK_NS * `CLK_MHZ + 999) / 1000)
`define MS_CYC       (1000 * `CLK_MHZ)
`define SAMPLE_US    100
`define SAMPLE_CYC   (`SAMPLE_US * `CLK_MHZ)

`endif

// *** logic/relay_pkg.sv ***
// Purpose: shared types of the relay scanner block
// Assumes: nothing beyond the defines header
// Notes:   bus requests travel as one packed struct
`default_nettype none
package relay_pkg;
  typedef struct packed {
    logic        we;
    logic        re;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } bus_req_t;

  typedef enum logic [2:0] {
    S_BOOT,
    S_IDLE,
    S_BREAK,
    S_FETCH,
    S_MAKE,
    S_SAVE
  } seq_state_t;
endpackage
`default_nettype wire

// *** logic/scan_list_mem.sv ***
// Purpose: 32 x 16 scan list store with registered read data
// Assumes: one write and one read port, same clock
// Notes:   contents are undefined until loaded from non-volatile storage
`default_nettype none
module scan_list_mem (
  // clock
  input  wire logic        sys_clk,
  // write port
  input  wire logic        we,
  input  wire logic [4:0]  waddr,
  input  wire logic [15:0] wdata,
  // read port
  input  wire logic        re,
  input  wire logic [4:0]  raddr,
  output logic      [15:0] rdata
);
  logic [15:0] mem [0:31];

  always_ff @(posedge sys_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    if (re) begin
      rdata <= mem[raddr];
    end
  end
endmodule
`default_nettype wire

// *** logic/input_monitor.sv ***
// Purpose: samples eight inputs into condition, filtered event and summary bits
// Assumes: inputs synchronous to sys_clk
// Notes:   sample period is a parameter so a bench can shorten it
`include "relay_defines.svh"
`default_nettype none
module input_monitor #(
  parameter int SAMPLE_CYCLES = `SAMPLE_CYC
) (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // pins
  input  wire logic [7:0] din,
  // control
  input  wire logic [7:0] ptr,
  input  wire logic [7:0] ntr,
  input  wire logic [7:0] ena,
  input  wire logic       ev_clr,
  // status
  output logic      [7:0] cond,
  output logic      [7:0] event_bits,
  output logic            summary
);
  logic [31:0] tick_cnt_r;
  logic        tick;
  logic [7:0]  rise;
  logic [7:0]  fall;
  logic [7:0]  hit;

  assign tick = (tick_cnt_r == 32'(SAMPLE_CYCLES - 1));
  assign rise = din & ~cond;
  assign fall = ~din & cond;
  assign hit  = tick ? ((rise & ptr) | (fall & ntr)) : 8'h00;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tick_cnt_r <= 32'h0000_0000;
      cond       <= 8'h00;
      event_bits <= 8'h00;
      summary    <= 1'b0;
    end else begin
      tick_cnt_r <= tick ? 32'h0000_0000 : tick_cnt_r + 32'h0000_0001;
      if (tick) begin
        cond <= din;
      end
      // a new edge wins over the clearing read
      event_bits <= hit | (ev_clr ? 8'h00 : event_bits);
      summary    <= |(event_bits & ena);
    end
  end
endmodule
`default_nettype wire

// *** logic/relay_scanner.sv ***
// Purpose: sixteen relay outputs with break-before-make scanner and input monitor
// Assumes: host commands arrive as register writes on a plain port
// Notes:   scan list restored from non-volatile storage before outputs enable
//
// Function
// - scan command stores ordered relay group list
// - immediate initiate goes to first position, enables
// - continuous setting enables or disables, reset disabled
// - bus or common trigger steps one position
// - open current group before closing next
// - relays outside list stay individually controlled
// - list holds 16 relays by 32 steps
// - save with argument zero writes list to flash
// - each group opens and closes together
// - trigger at last position returns home
// - condition read gives present input levels
// - event latches changes, read clears it
// - rise and fall masks select event edges
// - inputs sampled faster than 1 kHz
// - enabled events summarised, raise service request
// - outputs disabled until saved setup loaded
// - relay enable output asserted once outputs enabled
// - host list form decoded into relay masks; register writes carry masks directly
// - open or close changes only named relays
`include "relay_defines.svh"
`default_nettype none
module relay_scanner #(
  parameter int MS_CYCLES     = `MS_CYC,
  parameter int SAMPLE_CYCLES = `SAMPLE_CYC
) (
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst,
  // register port
  input  wire relay_pkg::bus_req_t req,
  output logic            [31:0] rd_data,
  // bus group execute trigger
  input  wire logic              get_trig,
  // digital inputs
  input  wire logic       [7:0]  din,
  // relay outputs
  output logic            [15:0] relay_out,
  output logic                   relay_en,
  output logic                   srq,
  // non-volatile storage
  output logic                   nv_rd_en,
  output logic                   nv_wr_en,
  output logic            [5:0]  nv_addr,
  output logic            [15:0] nv_wr_data,
  input  wire logic       [15:0] nv_rd_data
);
  function automatic logic wr_hit(input relay_pkg::bus_req_t r, input logic [7:0] a);
    return r.we && (r.addr == a);
  endfunction

  function automatic logic rd_hit(input relay_pkg::bus_req_t r, input logic [7:0] a);
    return r.re && (r.addr == a);
  endfunction

  relay_pkg::seq_state_t state_r;
  relay_pkg::seq_state_t state_nxt;

  logic [15:0]        indiv_r;
  logic [15:0]        scan_mask_r;
  logic [15:0]        scan_grp_r;
  logic [15:0]        pulse_mask_r;
  logic [15:0]        pwidth_r;
  logic [15:0]        pw_cnt_r;
  logic [31:0]        ms_cnt_r;
  logic [`LEN_W-1:0]  len_r;
  logic [4:0]         pos_r;
  logic [4:0]         target_r;
  logic               scan_en_r;
  logic               trig_pend_r;
  logic               init_pend_r;
  logic               save_pend_r;
  logic [6:0]         cnt_r;
  logic [7:0]         ptr_r;
  logic [7:0]         ntr_r;
  logic [7:0]         ena_r;

  // decoded bus strobes
  wire        w_close  = wr_hit(req, `A_CLOSE);
  wire        w_open   = wr_hit(req, `A_OPEN);
  wire        w_pulse  = wr_hit(req, `A_PULSE);
  wire        w_pwidth = wr_hit(req, `A_PWIDTH);
  wire        w_entry  = wr_hit(req, `A_SCAN_ENTRY);
  wire        w_len    = wr_hit(req, `A_SCAN_LEN);
  wire        w_init   = wr_hit(req, `A_INIT_IMM);
  wire        w_cont   = wr_hit(req, `A_INIT_CONT);
  wire        w_trig   = wr_hit(req, `A_TRIGGER);
  wire        w_save   = wr_hit(req, `A_SAVE) && (req.wdata == `SAVE_ARG);
  wire        ev_clr   = rd_hit(req, `A_EVENT);
  wire [15:0] wmask    = req.wdata[15:0];
  wire [4:0]  ent_idx  = req.wdata[`ENT_IDX_MSB:`ENT_IDX_LSB];
  wire        booting  = (state_r == relay_pkg::S_BOOT);
  wire        len_ok   = (len_r != 6'h00) && (len_r <= `STEPS);
  wire        pw_ok    = (wmask >= `PW_MIN) && (wmask <= `PW_MAX);

  // trigger handling and next position
  wire        trig_any = (get_trig || w_trig) && scan_en_r && !booting;
  wire        at_last  = ({1'b0, pos_r} == len_r - 6'h01);
  wire [4:0]  step_pos = at_last ? 5'h00 : pos_r + 5'h01;
  wire        idle     = (state_r == relay_pkg::S_IDLE);
  wire        take_ini = idle && init_pend_r && len_ok;
  wire        take_trg = idle && !init_pend_r && trig_pend_r && scan_en_r && len_ok;
  wire        take_sav = idle && !init_pend_r && !trig_pend_r && save_pend_r;

  // boot stream: nv word k arrives the cycle after it is asked for
  wire        boot_dat = booting && (cnt_r != 7'h00);
  wire [5:0]  boot_wrd = 6'(cnt_r - 7'h01);
  wire        boot_len = boot_dat && (boot_wrd == `NV_ADDR_LEN);
  wire        boot_ent = boot_dat && (boot_wrd != `NV_ADDR_LEN);
  wire [4:0]  boot_idx = 5'(boot_wrd - 6'h01);
  wire        boot_end = booting && (boot_wrd == `STEPS);

  // save stream: length first, then one list word per cycle
  wire        saving   = (state_r == relay_pkg::S_SAVE);
  wire [4:0]  save_idx = 5'(cnt_r);
  wire        save_end = saving && (cnt_r == 7'(`STEPS));

  // memory port selection
  wire        mem_we    = boot_ent || (w_entry && !booting);
  wire [4:0]  mem_waddr = booting ? boot_idx : ent_idx;
  wire [15:0] mem_wdata = booting ? nv_rd_data : wmask;
  wire        mem_re    = (state_r == relay_pkg::S_FETCH) || saving;
  wire [4:0]  mem_raddr = saving ? save_idx : target_r;
  wire [15:0] mem_rdata;

  // pulse timer, shared by every pulsed relay
  wire        ms_tick  = (ms_cnt_r == 32'(MS_CYCLES - 1));
  wire        pw_done  = (pulse_mask_r != 16'h0000) && ms_tick && (pw_cnt_r == 16'h0001);

  // individual latch: only named relays move
  wire [15:0] indiv_nxt = ((indiv_r
                          | (w_close ? wmask : 16'h0000)
                          | (w_pulse ? wmask : 16'h0000))
                          & ~(w_open ? wmask : 16'h0000)
                          & ~(pw_done ? pulse_mask_r : 16'h0000));

  // scan relays follow the scanner, the rest follow the latch
  wire [15:0] out_nxt = booting ? 16'h0000
                      : ((indiv_r & ~scan_mask_r) | (scan_grp_r & scan_mask_r));

  wire [7:0]  cond;
  wire [7:0]  event_bits;
  wire        summary;
  wire [7:0]  stb = summary ? ((8'h01 << `SB_RQS) | (8'h01 << `SB_QSUM))
                            : 8'h00;

  logic [31:0] rd_mux;
  always_comb begin
    case (req.addr)
      `A_STATE:     rd_mux = {16'h0000, relay_out};
      `A_PWIDTH:    rd_mux = {16'h0000, pwidth_r};
      `A_SCAN_LEN:  rd_mux = {26'h000_0000, len_r};
      `A_INIT_CONT: rd_mux = {31'h0000_0000, scan_en_r};
      `A_SCAN_STAT: rd_mux = {16'h0000, 3'b000, pos_r, 5'h00, saving, booting, idle};
      `A_COND:      rd_mux = {24'h00_0000, cond};
      `A_EVENT:     rd_mux = {24'h00_0000, event_bits};
      `A_ENABLE:    rd_mux = {24'h00_0000, ena_r};
      `A_PTR:       rd_mux = {24'h00_0000, ptr_r};
      `A_NTR:       rd_mux = {24'h00_0000, ntr_r};
      `A_STB:       rd_mux = {24'h00_0000, stb};
      default:      rd_mux = 32'h0000_0000;
    endcase
  end

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      relay_pkg::S_BOOT: begin
        if (boot_end) begin
          state_nxt = relay_pkg::S_IDLE;
        end
      end
      relay_pkg::S_IDLE: begin
        if (take_ini || take_trg) begin
          state_nxt = relay_pkg::S_BREAK;
        end else if (take_sav) begin
          state_nxt = relay_pkg::S_SAVE;
        end
      end
      relay_pkg::S_BREAK: begin
        if (cnt_r == 7'(`BREAK_CYC)) begin
          state_nxt = relay_pkg::S_FETCH;
        end
      end
      relay_pkg::S_FETCH: state_nxt = relay_pkg::S_MAKE;
      relay_pkg::S_MAKE:  state_nxt = relay_pkg::S_IDLE;
      relay_pkg::S_SAVE: begin
        if (save_end) begin
          state_nxt = relay_pkg::S_IDLE;
        end
      end
      default: state_nxt = relay_pkg::S_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_r <= relay_pkg::S_BOOT;
      cnt_r   <= 7'h00;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= (state_nxt != state_r) ? 7'h00 : cnt_r + 7'h01;
    end
  end

  // scanner position, group and enable
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      scan_en_r   <= 1'b0;
      scan_grp_r  <= 16'h0000;
      pos_r       <= 5'h00;
      target_r    <= 5'h00;
      trig_pend_r <= 1'b0;
      init_pend_r <= 1'b0;
    end else begin
      trig_pend_r <= trig_any || (trig_pend_r && !take_trg && scan_en_r);
      init_pend_r <= (w_init && !booting) || (init_pend_r && !take_ini);
      if (w_len) begin
        scan_en_r <= 1'b0;
      end else if (take_ini) begin
        scan_en_r <= 1'b1;
      end else if (w_cont) begin
        scan_en_r <= req.wdata[0];
      end
      if (take_ini) begin
        target_r <= 5'h00;
      end else if (take_trg) begin
        target_r <= step_pos;
      end
      if (state_r == relay_pkg::S_BREAK || w_len) begin
        scan_grp_r <= 16'h0000;
      end else if (state_r == relay_pkg::S_MAKE) begin
        scan_grp_r <= mem_rdata;
        pos_r      <= target_r;
      end
    end
  end

  // scan list bookkeeping and flash handshake
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      len_r       <= 6'h00;
      scan_mask_r <= 16'h0000;
      save_pend_r <= 1'b0;
      nv_rd_en    <= 1'b0;
      nv_wr_en    <= 1'b0;
      nv_addr     <= 6'h00;
      nv_wr_data  <= 16'h0000;
    end else begin
      save_pend_r <= (w_save && !booting) || (save_pend_r && !take_sav);
      if (boot_len) begin
        len_r <= nv_rd_data[`LEN_W-1:0];
      end else if (w_len && !booting) begin
        len_r <= req.wdata[`LEN_W-1:0];
      end
      if (w_len && !booting) begin
        scan_mask_r <= 16'h0000;
      end else if (boot_ent && ({1'b0, boot_idx} < len_r)) begin
        scan_mask_r <= scan_mask_r | nv_rd_data;
      end else if (w_entry && !booting) begin
        scan_mask_r <= scan_mask_r | wmask;
      end
      nv_rd_en <= booting && !boot_end && (cnt_r <= 7'(`STEPS));
      if (take_sav) begin
        nv_wr_en   <= 1'b1;
        nv_addr    <= `NV_ADDR_LEN;
        nv_wr_data <= {10'h000, len_r};
      end else if (saving && cnt_r != 7'h00) begin
        nv_wr_en   <= 1'b1;
        nv_addr    <= 6'(cnt_r);
        nv_wr_data <= mem_rdata;
      end else if (booting) begin
        nv_wr_en <= 1'b0;
        nv_addr  <= 6'(cnt_r);
      end else begin
        nv_wr_en <= 1'b0;
      end
    end
  end

  // individual latches, pulse timer and monitor setup
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      indiv_r      <= 16'h0000;
      pulse_mask_r <= 16'h0000;
      pwidth_r     <= `PW_DEFAULT;
      pw_cnt_r     <= 16'h0000;
      ms_cnt_r     <= 32'h0000_0000;
      ptr_r        <= 8'h00;
      ntr_r        <= 8'h00;
      ena_r        <= 8'h00;
    end else begin
      indiv_r <= indiv_nxt;
      if (w_pwidth && pw_ok) begin
        pwidth_r <= wmask;
      end
      // a fresh pulse restarts the shared timer for all pulsed relays
      if (w_pulse) begin
        pulse_mask_r <= (pw_done ? 16'h0000 : pulse_mask_r) | wmask;
        pw_cnt_r     <= pwidth_r;
        ms_cnt_r     <= 32'h0000_0000;
      end else begin
        pulse_mask_r <= pw_done ? 16'h0000 : pulse_mask_r;
        ms_cnt_r     <= ms_tick ? 32'h0000_0000 : ms_cnt_r + 32'h0000_0001;
        if (ms_tick && pw_cnt_r != 16'h0000) begin
          pw_cnt_r <= pw_cnt_r - 16'h0001;
        end
      end
      if (wr_hit(req, `A_PTR)) begin
        ptr_r <= req.wdata[7:0];
      end
      if (wr_hit(req, `A_NTR)) begin
        ntr_r <= req.wdata[7:0];
      end
      if (wr_hit(req, `A_ENABLE)) begin
        ena_r <= req.wdata[7:0];
      end
    end
  end

  // registered outputs
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      relay_out <= 16'h0000;
      relay_en  <= 1'b0;
      srq       <= 1'b0;
      rd_data   <= 32'h0000_0000;
    end else begin
      relay_out <= out_nxt;
      relay_en  <= !booting;
      srq       <= summary;
      rd_data   <= req.re ? rd_mux : 32'h0000_0000;
    end
  end

  scan_list_mem u_mem (
    .sys_clk (sys_clk),
    .we      (mem_we),
    .waddr   (mem_waddr),
    .wdata   (mem_wdata),
    .re      (mem_re),
    .raddr   (mem_raddr),
    .rdata   (mem_rdata)
  );

  input_monitor #(
    .SAMPLE_CYCLES (SAMPLE_CYCLES)
  ) u_mon (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .din        (din),
    .ptr        (ptr_r),
    .ntr        (ntr_r),
    .ena        (ena_r),
    .ev_clr     (ev_clr),
    .cond       (cond),
    .event_bits (event_bits),
    .summary    (summary)
  );
endmodule
`default_nettype wire

// *** sim/relay_scanner_monitor.sv ***
// Purpose: concurrent checks on the relay scanner ports
// Assumes: one clock domain, rst synchronous active high
// Notes:   bound to every relay_scanner instance
`include "relay_defines.svh"
`default_nettype none
module relay_scanner_monitor #(
  parameter int MS_CYCLES     = 10,
  parameter int SAMPLE_CYCLES = 4
) (
  // clock and reset
  input wire logic                sys_clk,
  input wire logic                rst,
  // register port
  input wire relay_pkg::bus_req_t req,
  input wire logic         [31:0] rd_data,
  input wire logic                get_trig,
  input wire logic         [7:0]  din,
  // outputs
  input wire logic         [15:0] relay_out,
  input wire logic                relay_en,
  input wire logic                srq,
  // non-volatile storage
  input wire logic                nv_rd_en,
  input wire logic                nv_wr_en,
  input wire logic         [5:0]  nv_addr,
  input wire logic         [15:0] nv_wr_data,
  input wire logic         [15:0] nv_rd_data
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_boot_quiet: assert property (!relay_en |-> relay_out == 16'h0000)
    else $error("relay output driven while disabled");
  a_load_first: assert property (nv_rd_en |-> !relay_en)
    else $error("outputs enabled during setup load");
  a_enable_holds: assert property (relay_en |=> relay_en)
    else $error("relay enable dropped");
  a_enable_bound: assert property ($fell(rst) |-> ##[1:60] relay_en)
    else $error("relay enable late");
  a_boot_walk: assert property (nv_rd_en && !relay_en && nv_addr < 6'h20
    |=> nv_rd_en && nv_addr == $past(nv_addr) + 6'h01)
    else $error("boot load skipped a word");
  a_break_first: assert property ((relay_out & ~$past(relay_out)) != 16'h0000
    |-> ($past(relay_out) & ~relay_out) == 16'h0000)
    else $error("relay closed in the cycle another opened");
  a_state_read: assert property (req.re && req.addr == `A_STATE
    |=> rd_data[15:0] == $past(relay_out))
    else $error("state read differs from outputs");
  a_summary_pair: assert property (req.re && req.addr == `A_STB
    |=> rd_data[`SB_QSUM] == rd_data[`SB_RQS] && srq == rd_data[`SB_RQS])
    else $error("summary and request disagree");
  a_save_starts: assert property (req.we && req.addr == `A_SAVE && req.wdata == `SAVE_ARG
    && relay_en |-> ##[1:40] nv_wr_en && nv_addr == `NV_ADDR_LEN)
    else $error("save did not start");
  a_save_burst: assert property (nv_wr_en && nv_addr == `NV_ADDR_LEN
    |=> !nv_wr_en ##1 nv_wr_en && nv_addr == 6'h01)
    else $error("save burst broken");
  a_save_refused: assert property (req.we && req.addr == `A_SAVE && req.wdata != `SAVE_ARG
    && !nv_wr_en |=> !nv_wr_en [*8])
    else $error("save ran with nonzero argument");
endmodule

bind relay_scanner relay_scanner_monitor #(
  .MS_CYCLES(MS_CYCLES), .SAMPLE_CYCLES(SAMPLE_CYCLES)) i_mon (
  .sys_clk(sys_clk), .rst(rst), .req(req), .rd_data(rd_data), .get_trig(get_trig),
  .din(din), .relay_out(relay_out), .relay_en(relay_en), .srq(srq), .nv_rd_en(nv_rd_en),
  .nv_wr_en(nv_wr_en), .nv_addr(nv_addr), .nv_wr_data(nv_wr_data), .nv_rd_data(nv_rd_data));
`default_nettype wire

// *** sim/flash_model.sv ***
// Purpose: non-volatile word store seen by the relay scanner
// Assumes: read data valid while the requested address stands
// Notes:   holds a 3-step list at power-up
`default_nettype none
module flash_model (
  // clock
  input wire logic        sys_clk,
  // access
  input wire logic        nv_rd_en,
  input wire logic        nv_wr_en,
  input wire logic [5:0]  nv_addr,
  input wire logic [15:0] nv_wr_data,
  output logic     [15:0] nv_rd_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [0:32];

  initial begin
    for (int i = 0; i < 33; i++) mem[i] = 16'h0000;
    mem[0] = 16'h0003;
    mem[1] = 16'h0003;
    mem[2] = 16'h0014;
    mem[3] = 16'h0060;
  end

  // boot load takes word k in the cycle its address stands on the port
  // an idle port shows the inverse so stale data is never mistaken for valid
  assign nv_rd_data = nv_rd_en ? mem[nv_addr] : ~mem[nv_addr];

  always @(posedge sys_clk) begin
    if (nv_wr_en) mem[nv_addr] <= nv_wr_data;
  end
endmodule
`default_nettype wire

// *** sim/tb_top.sv ***
// Purpose: self-checking bench for the relay scanner
// Assumes: shortened ms and sample counts
// Notes:   flash contents inspected through the model hierarchy
`include "relay_defines.svh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MS  = 10;
  localparam int SMP = 4;
  logic                sys_clk  = 1'b0;
  logic                rst      = 1'b1;
  relay_pkg::bus_req_t req      = '0;
  logic                get_trig = 1'b0;
  logic         [7:0]  din      = 8'h00;
  logic         [31:0] rd_data;
  logic         [15:0] relay_out;
  logic                relay_en;
  logic                srq;
  logic                nv_rd_en;
  logic                nv_wr_en;
  logic         [5:0]  nv_addr;
  logic         [15:0] nv_wr_data;
  logic         [15:0] nv_rd_data;
  logic         [31:0] d;
  logic         [15:0] g;
  int                  errors      = 0;
  int                  check_count = 0;
  int                  cyc         = 0;

  relay_scanner #(.MS_CYCLES(MS), .SAMPLE_CYCLES(SMP)) i_dut (
    .sys_clk(sys_clk), .rst(rst), .req(req), .rd_data(rd_data), .get_trig(get_trig),
    .din(din), .relay_out(relay_out), .relay_en(relay_en), .srq(srq), .nv_rd_en(nv_rd_en),
    .nv_wr_en(nv_wr_en), .nv_addr(nv_addr), .nv_wr_data(nv_wr_data),
    .nv_rd_data(nv_rd_data));
  flash_model i_flash (
    .sys_clk(sys_clk), .nv_rd_en(nv_rd_en), .nv_wr_en(nv_wr_en), .nv_addr(nv_addr),
    .nv_wr_data(nv_wr_data), .nv_rd_data(nv_rd_data));

  always #2.5 sys_clk = ~sys_clk;

  task automatic summarize;
    $display("counts: %0d checks, %0d mismatches", check_count, errors);
    if (errors == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      summarize();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // strobe drops at the taking edge, so back-to-back calls never double-drive it
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    req.addr  <= a;
    req.wdata <= v;
    req.we    <= 1'b1;
    @(posedge sys_clk);
    req.we <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a);
    req.addr <= a;
    req.re   <= 1'b1;
    @(posedge sys_clk);
    req.re <= 1'b0;
    #1 d = rd_data;
  endtask
  task automatic state_is(input logic [15:0] exp, input string what);
    wt(3);
    rd(`A_STATE);
    chk(d, {16'h0000, exp}, what);
  endtask
  task automatic trig(input bit on_pin);
    if (on_pin) begin
      get_trig <= 1'b1;
      @(posedge sys_clk);
      get_trig <= 1'b0;
      #1;
    end else wr(`A_TRIGGER, 32'h0000_0000);
    wt(40);
  endtask

  initial begin
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    for (int i = 0; i < 100 && relay_en !== 1'b1; i++) begin
      wt(1);
      if (relay_en !== 1'b1) chk(32'(relay_out), 32'h0, "output before enable");
    end
    chk(32'(relay_en), 32'h1, "relay enable");
    rd(`A_INIT_CONT);
    chk(d, 32'h0000_0000, "continuous default");
    rd(`A_PWIDTH);
    chk(d, 32'h0000_0019, "width default");
    rd(8'hFC);
    chk(d, 32'h0000_0000, "unmapped read");
    wr(`A_CLOSE, 32'h0000_0101);
    wr(`A_OPEN, 32'h0000_0001);
    state_is(16'h0100, "individual control");
    $display("test individual done");

    wr(`A_INIT_IMM, 32'h0000_0000);
    wt(40);
    state_is(16'h0103, "restored first position");
    trig(1);
    state_is(16'h0114, "pin trigger step");
    trig(0);
    state_is(16'h0160, "common trigger step");
    trig(1);
    state_is(16'h0103, "wrap to home");
    wr(`A_INIT_CONT, 32'h0000_0000);
    trig(1);
    state_is(16'h0103, "trigger while disabled");
    wr(`A_INIT_CONT, 32'h0000_0001);
    rd(`A_INIT_CONT);
    chk(d, 32'h0000_0001, "continuous set");
    trig(0);
    state_is(16'h0114, "step after enable");
    $display("test restored scan done");

    wr(`A_SCAN_LEN, 32'h0000_0020);
    wt(30);
    state_is(16'h0100, "list cleared");
    for (int i = 0; i < 32; i++) begin
      g = (i == 0) ? 16'h8000 : (i == 31) ? 16'h4000 : 16'h2000;
      wr(`A_SCAN_ENTRY, {11'h000, i[4:0], g});
    end
    wr(`A_INIT_IMM, 32'h0000_0000);
    wt(40);
    state_is(16'h8100, "new list first position");
    for (int i = 0; i < 30; i++) trig(1);
    state_is(16'h2100, "middle position");
    trig(0);
    state_is(16'h4100, "last of 32 steps");
    rd(`A_SCAN_STAT);
    chk(d, 32'h0000_1F01, "position 31 idle");
    trig(1);
    state_is(16'h8100, "wrap after 32 steps");
    $display("test full list done");

    wr(`A_SAVE, 32'h0000_0001);
    wt(10);
    chk(32'(i_flash.mem[0]), 32'h0000_0003, "save refused");
    wr(`A_SAVE, `SAVE_ARG);
    wt(60);
    chk(32'(i_flash.mem[0]), 32'h0000_0020, "saved length");
    chk(32'(i_flash.mem[32]), 32'h0000_4000, "saved last step");
    $display("test save done");

    wr(`A_PWIDTH, 32'h0000_0000);
    rd(`A_PWIDTH);
    chk(d, 32'h0000_0019, "width bound");
    wr(`A_PWIDTH, 32'h0000_0002);
    wr(`A_PULSE, 32'h0000_0010);
    state_is(16'h8110, "pulse closed");
    wt(30);
    state_is(16'h8100, "pulse ended");
    $display("test pulse done");

    wr(`A_PTR, 32'h0000_0001);
    wr(`A_NTR, 32'h0000_0002);
    wr(`A_ENABLE, 32'h0000_0002);
    rd(`A_EVENT);
    din <= 8'h03;
    wt(12);
    rd(`A_COND);
    chk(d, 32'h0000_0003, "input levels");
    rd(`A_EVENT);
    chk(d, 32'h0000_0001, "rising filter");
    din <= 8'h00;
    wt(12);
    rd(`A_STB);
    chk(d & 32'h0000_0048, 32'h0000_0048, "summary set");
    chk(32'(srq), 32'h1, "service request");
    rd(`A_EVENT);
    chk(d, 32'h0000_0002, "falling filter");
    rd(`A_EVENT);
    chk(d, 32'h0000_0000, "read clears");
    wt(4);
    chk(32'(srq), 32'h0, "request withdrawn");
    $display("test inputs done");
    summarize();
  end
endmodule
`default_nettype wire
